// file: common/sacs_pkg.sv
// Shared constants and types for the converter conversion sequencer
package sacs_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DIV_W = 3;
  localparam int CH_W = 5;
  localparam int REF_W = 2;
  localparam int RES_W = 10;
  localparam int PSC_W = 7;
  localparam int HALF_W = 6;
  localparam int CYC_W = 5;
  localparam int TRIG_SYNC_STAGES = 3;
  // ****************************************
  // Result and prescaler values
  // ****************************************
  localparam logic [RES_W-1:0] RES_MAX = 10'h3FF;
  localparam logic [DIV_W-1:0] DIV_MIN_SHIFT = 3'h1;
  // ****************************************
  // Conversion timing in half converter clock cycles; NORMAL_CYC and FIRST_CYC in whole cycles
  // ****************************************
  localparam logic [HALF_W-1:0] TOT_NORMAL_H = 6'h1A;
  localparam logic [HALF_W-1:0] TOT_FIRST_H = 6'h32;
  localparam logic [HALF_W-1:0] TOT_AUTO_H = 6'h1B;
  localparam logic [HALF_W-1:0] SMP_NORMAL_H = 6'h03;
  localparam logic [HALF_W-1:0] SMP_FIRST_H = 6'h1D;
  localparam logic [HALF_W-1:0] SMP_AUTO_H = 6'h04;
  localparam logic [HALF_W-1:0] HALF_ONE = 6'h01;
  localparam logic [HALF_W:0] LAST_CYC_H = 7'h02;
  localparam logic [CYC_W-1:0] NORMAL_CYC = 5'h0D;
  localparam logic [CYC_W-1:0] FIRST_CYC = 5'h19;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    SACS_IDLE = 2'b00,
    SACS_WAIT = 2'b01,
    SACS_CONV = 2'b10
  } sacs_state_t;
endpackage

// file: hw/sacs_prescaler.sv
// Converter clock prescaler giving rising and falling tick pulses
module sacs_prescaler #(
  parameter int DIV_W = sacs_pkg::DIV_W,
  parameter int CNT_W = sacs_pkg::PSC_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [DIV_W-1:0] i_divide_select,
  output logic o_rise,
  output logic o_fall
);
  // ****************************************
  // Ratio decode
  // ****************************************
  generate
    if (CNT_W < (1 << DIV_W) - 1) begin : g_bad_width
      $error("Prescaler counter too narrow for the divide select field");
    end
  endgenerate

  // Select zero maps to the smallest ratio, so no ratio of one exists
  function automatic logic [CNT_W:0] ratio_of(input logic [DIV_W-1:0] sel);
    logic [DIV_W-1:0] sh;
    sh = (sel < sacs_pkg::DIV_MIN_SHIFT) ? sacs_pkg::DIV_MIN_SHIFT : sel;
    ratio_of = (CNT_W+1)'(1) << sh;
  endfunction

  logic [CNT_W:0] ratio;
  logic [CNT_W-1:0] term;
  logic [CNT_W-1:0] half_term;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign ratio = ratio_of(i_divide_select);
  assign term = CNT_W'(ratio - (CNT_W+1)'(1));
  assign half_term = CNT_W'((ratio >> 1) - (CNT_W+1)'(1));

  // ****************************************
  // Counter
  // ****************************************
  always_comb begin
    // A ratio cut while running must not strand the count past the new end
    o_rise = i_run && !i_restart && (cnt_q >= term);
    o_fall = i_run && !i_restart && (cnt_q == half_term);
    if (!i_run || i_restart || o_rise) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: hw/sacs_sequencer.sv
// Conversion sequencer for a 10-bit successive-approximation converter

module sacs_sequencer #(
  parameter int DIV_W = sacs_pkg::DIV_W,
  parameter int CH_W = sacs_pkg::CH_W,
  parameter int REF_W = sacs_pkg::REF_W
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_converter_enable,
  input wire logic [DIV_W-1:0] i_clock_divide_select,
  input wire logic i_start_write,
  input wire logic i_auto_trigger_enable,
  input wire logic i_free_running,
  input wire logic i_trigger,
  input wire logic i_select_write,
  input wire logic [CH_W-1:0] i_channel_select_field,
  input wire logic [REF_W-1:0] i_reference_select_field,
  input wire logic i_sleep_halted,
  input wire logic i_result_low_read,
  input wire logic i_result_high_read,
  input wire logic i_done_flag_clear,
  input wire logic [sacs_pkg::RES_W-1:0] i_sar_result,
  input wire logic i_over_range,
  output logic o_start_conversion_bit,
  output logic o_conversion_done_flag,
  output logic o_complete_request,
  output logic o_converting,
  output logic o_sample_hold,
  output logic [sacs_pkg::RES_W-1:0] o_result,
  output logic [CH_W-1:0] o_active_channel,
  output logic [REF_W-1:0] o_active_reference
);
  localparam int HW = sacs_pkg::HALF_W;
  localparam int RW = sacs_pkg::RES_W;
  localparam int TS = sacs_pkg::TRIG_SYNC_STAGES;

  generate
    if (DIV_W > sacs_pkg::DIV_W || CH_W < 1 || REF_W < 1) begin : g_bad_param
      $error("Unsupported sequencer parameters");
    end
  endgenerate

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  logic rise;
  logic fall;
  logic auto_go;

  sacs_prescaler #(.DIV_W(DIV_W), .CNT_W(sacs_pkg::PSC_W)) u_prescaler (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_run(i_converter_enable),
    .i_restart(auto_go),
    .i_divide_select(i_clock_divide_select),
    .o_rise(rise),
    .o_fall(fall)
  );

  // ****************************************
  // Conversion sequencing
  // ****************************************
  sacs_pkg::sacs_state_t st_q, st_d;
  logic [HW-1:0] half_q, half_d, tot_q, tot_d, smp_q, smp_d;
  logic [TS-1:0] trig_q, trig_d;
  logic trig_old_q, en_q, sleep_q, first_q, first_d;
  logic start_q, start_d, busy_q, busy_d, smp_pulse_q, smp_pulse_d;
  logic done_q, done_d, cmpl_q, complete, restart, trig_edge, sleep_go;

  always_comb begin
    trig_d = {trig_q[TS-2:0], i_trigger};
    trig_edge = trig_q[TS-1] && !trig_old_q;
    auto_go = i_converter_enable && i_auto_trigger_enable && trig_edge
      && (st_q == sacs_pkg::SACS_IDLE);
    sleep_go = i_converter_enable && !i_auto_trigger_enable && i_sleep_halted
      && !sleep_q && (st_q == sacs_pkg::SACS_IDLE) && !start_q;
    restart = i_free_running && i_auto_trigger_enable;
    st_d = st_q;
    half_d = half_q;
    tot_d = tot_q;
    smp_d = smp_q;
    first_d = first_q || (i_converter_enable && !en_q);
    complete = 1'b0;
    smp_pulse_d = 1'b0;
    unique case (st_q)
      sacs_pkg::SACS_IDLE: begin
        if (auto_go) begin
          st_d = sacs_pkg::SACS_CONV;
          half_d = '0;
          tot_d = first_q ? sacs_pkg::TOT_FIRST_H : sacs_pkg::TOT_AUTO_H;
          smp_d = first_q ? sacs_pkg::SMP_FIRST_H : sacs_pkg::SMP_AUTO_H;
          first_d = 1'b0;
        end else if (start_q || i_start_write || sleep_go) begin
          st_d = sacs_pkg::SACS_WAIT;
        end
      end
      sacs_pkg::SACS_WAIT: begin
        if (rise) begin
          st_d = sacs_pkg::SACS_CONV;
          half_d = '0;
          tot_d = first_q ? sacs_pkg::TOT_FIRST_H : sacs_pkg::TOT_NORMAL_H;
          smp_d = first_q ? sacs_pkg::SMP_FIRST_H : sacs_pkg::SMP_NORMAL_H;
          first_d = 1'b0;
        end
      end
      sacs_pkg::SACS_CONV: begin
        if (rise || fall) begin
          half_d = half_q + sacs_pkg::HALF_ONE;
          smp_pulse_d = (half_d == smp_q);
          if (half_d == tot_q) begin
            complete = 1'b1;
            if (restart) begin
              half_d = '0;
              tot_d = sacs_pkg::TOT_NORMAL_H;
              smp_d = sacs_pkg::SMP_NORMAL_H;
            end else begin
              st_d = sacs_pkg::SACS_IDLE;
            end
          end
        end
      end
      default: st_d = sacs_pkg::SACS_IDLE;
    endcase
    // Disabling aborts any conversion; the next one counts as first again
    if (!i_converter_enable) begin
      st_d = sacs_pkg::SACS_IDLE;
      complete = 1'b0;
      smp_pulse_d = 1'b0;
    end
    busy_d = (st_d == sacs_pkg::SACS_CONV);
    // A fresh write wins over the clear at completion
    start_d = start_q || auto_go || sleep_go;
    if (complete && !restart) begin
      start_d = 1'b0;
    end
    if (restart && busy_d) begin
      start_d = 1'b1;
    end
    if (i_start_write) begin
      start_d = 1'b1;
    end
    if (!i_converter_enable) begin
      start_d = 1'b0;
    end
    done_d = complete || (done_q && !i_done_flag_clear);
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= sacs_pkg::SACS_IDLE;
      half_q <= '0;
      tot_q <= sacs_pkg::TOT_NORMAL_H;
      smp_q <= sacs_pkg::SMP_NORMAL_H;
      trig_q <= '0;
      trig_old_q <= 1'b0;
      en_q <= 1'b0;
      sleep_q <= 1'b0;
      first_q <= 1'b0;
      start_q <= 1'b0;
      busy_q <= 1'b0;
      smp_pulse_q <= 1'b0;
      done_q <= 1'b0;
      cmpl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      half_q <= half_d;
      tot_q <= tot_d;
      smp_q <= smp_d;
      trig_q <= trig_d;
      trig_old_q <= trig_q[TS-1];
      en_q <= i_converter_enable;
      sleep_q <= i_sleep_halted;
      first_q <= first_d;
      start_q <= start_d;
      busy_q <= busy_d;
      smp_pulse_q <= smp_pulse_d;
      done_q <= done_d;
      cmpl_q <= complete;
    end
  end

  // ****************************************
  // Selection buffering and result store
  // ****************************************
  logic [CH_W-1:0] tmp_ch_q, tmp_ch_d, act_ch_q, act_ch_d;
  logic [REF_W-1:0] tmp_ref_q, tmp_ref_d, act_ref_q, act_ref_d;
  logic [RW-1:0] res_q, res_d;
  logic lock_d, block_q, block_d;

  always_comb begin
    tmp_ch_d = i_select_write ? i_channel_select_field : tmp_ch_q;
    tmp_ref_d = i_select_write ? i_reference_select_field : tmp_ref_q;
    // Lock from the start edge until the last converter cycle begins
    lock_d = busy_d && (({1'b0, half_d} + sacs_pkg::LAST_CYC_H) < {1'b0, tot_d});
    act_ch_d = lock_d ? act_ch_q : tmp_ch_q;
    act_ref_d = lock_d ? act_ref_q : tmp_ref_q;
    block_d = block_q;
    if (i_result_low_read) begin
      block_d = 1'b1;
    end
    if (i_result_high_read) begin
      block_d = 1'b0;
    end
    res_d = res_q;
    if (complete && !block_q) begin
      res_d = i_over_range ? sacs_pkg::RES_MAX : i_sar_result;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmp_ch_q <= '0;
      tmp_ref_q <= '0;
      act_ch_q <= '0;
      act_ref_q <= '0;
      block_q <= 1'b0;
      res_q <= '0;
    end else begin
      tmp_ch_q <= tmp_ch_d;
      tmp_ref_q <= tmp_ref_d;
      act_ch_q <= act_ch_d;
      act_ref_q <= act_ref_d;
      block_q <= block_d;
      res_q <= res_d;
    end
  end

  assign o_start_conversion_bit = start_q;
  assign o_conversion_done_flag = done_q;
  assign o_complete_request = cmpl_q;
  assign o_converting = busy_q;
  assign o_sample_hold = smp_pulse_q;
  assign o_result = res_q;
  assign o_active_channel = act_ch_q;
  assign o_active_reference = act_ref_q;

  // ****************************************
  // Checks
  // ****************************************
  logic [sacs_pkg::CYC_W-1:0] rc_q, rc_d, len_q, len_d;

  always_comb begin
    rc_d = (st_q != sacs_pkg::SACS_CONV || complete) ? '0
      : rc_q + sacs_pkg::CYC_W'(rise);
    len_d = complete ? rc_q + sacs_pkg::CYC_W'(rise) : len_q;
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rc_q <= '0;
      len_q <= '0;
    end else begin
      rc_q <= rc_d;
      len_q <= len_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  sequence s_free_done;
    complete && restart ##1 busy_q && start_q;
  endsequence

  a_busy_start_bit: assert property (busy_q |-> start_q)
    else $error("Start bit low during a conversion");
  a_prescaler_hold: assert property (!i_converter_enable |-> !rise && !fall)
    else $error("Prescaler ticked while disabled");
  a_done_sets: assert property (complete |=> done_q && cmpl_q)
    else $error("Completion did not set the done flag");
  a_single_clears: assert property (complete && !restart && !i_start_write
      |=> !start_q && !busy_q)
    else $error("Start bit not cleared at single completion");
  a_normal_length: assert property (cmpl_q && $past(tot_q) == sacs_pkg::TOT_NORMAL_H
      |-> len_q == sacs_pkg::NORMAL_CYC)
    else $error("Normal conversion length wrong");
  a_first_length: assert property (cmpl_q && $past(tot_q) == sacs_pkg::TOT_FIRST_H
      |-> len_q == sacs_pkg::FIRST_CYC)
    else $error("First conversion length wrong");
  a_trig_sync: assert property (auto_go |-> $past(i_trigger, 3) && !$past(i_trigger, 4))
    else $error("Trigger start not three cycles after its edge");
  a_auto_sample: assert property (auto_go && !first_q
      |-> ##[1:1000] o_sample_hold)
    else $error("No sample after trigger");
  a_lock_hold: assert property (busy_q && lock_d && $past(busy_q)
      |=> $stable(o_active_channel) && $stable(o_active_reference))
    else $error("Selection changed while locked");
  a_result_block: assert property (block_q && !i_result_high_read && complete
      |=> $stable(o_result) && done_q)
    else $error("Result updated while blocked");
  a_free_restart: assert property (complete && restart |-> s_free_done)
    else $error("Free running did not restart");
  a_trig_ignored: assert property (busy_q && trig_edge && !complete && i_converter_enable
      |=> busy_q && half_q >= $past(half_q))
    else $error("Trigger edge accepted during conversion");
endmodule

// file: test/sacs_afe_model.sv
// Analog front end model: multiplexer and sample-and-hold feeding the converter
module sacs_afe_model (
  input wire logic i_mclk,
  input wire logic i_sample_hold,
  input wire logic [sacs_pkg::CH_W-1:0] i_active_channel,
  input wire logic [sacs_pkg::REF_W-1:0] i_active_reference,
  input wire logic i_saturate,
  output logic [sacs_pkg::RES_W-1:0] o_sar_result,
  output logic o_over_range
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Held code
  // ****************************************
  // Code names the channel and reference held, so a late switch shows up
  initial o_sar_result = 10'h000;
  always @(posedge i_mclk) begin
    if (i_sample_hold) begin
      o_sar_result <= {i_active_reference, 3'h5, i_active_channel};
    end
  end
  // Input above the reference saturates the converter
  assign o_over_range = i_saturate;
endmodule

// file: test/tb.sv
// Self-checking testbench of the conversion sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_nrst, i_converter_enable, i_start_write, i_auto_trigger_enable;
  logic i_free_running, i_trigger, i_select_write, i_sleep_halted, saturate;
  logic i_result_low_read, i_result_high_read, i_done_flag_clear, i_over_range;
  logic [2:0] i_clock_divide_select;
  logic [4:0] i_channel_select_field, o_active_channel;
  logic [1:0] i_reference_select_field, o_active_reference;
  logic [9:0] i_sar_result, o_result;
  logic o_start_conversion_bit, o_conversion_done_flag, o_complete_request;
  logic o_converting, o_sample_hold;
  int fail_count, checked, k, s;
  sacs_sequencer i_sacs_sequencer (
    .i_mclk, .i_nrst, .i_converter_enable, .i_clock_divide_select, .i_start_write,
    .i_auto_trigger_enable, .i_free_running, .i_trigger, .i_select_write,
    .i_channel_select_field, .i_reference_select_field, .i_sleep_halted,
    .i_result_low_read, .i_result_high_read, .i_done_flag_clear, .i_sar_result,
    .i_over_range, .o_start_conversion_bit, .o_conversion_done_flag,
    .o_complete_request, .o_converting, .o_sample_hold, .o_result,
    .o_active_channel, .o_active_reference
  );
  sacs_afe_model i_sacs_afe_model (
    .i_mclk, .i_sample_hold(o_sample_hold), .i_active_channel(o_active_channel),
    .i_active_reference(o_active_reference), .i_saturate(saturate),
    .o_sar_result(i_sar_result), .o_over_range(i_over_range)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(int n = 1);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hang(string nm);
    $display("mismatch %s expected done seen timeout", nm);
    fail_count++;
    end_of_test();
  endtask
  task automatic pulse(ref logic p);
    p = 1;
    tick();
    p = 0;
  endtask
  task automatic sel(logic [4:0] c, logic [1:0] r);
    i_channel_select_field = c;
    i_reference_select_field = r;
    pulse(i_select_write);
  endtask
  function automatic logic [9:0] code(logic [1:0] r, logic [4:0] c);
    return {r, 3'h5, c};
  endfunction
  // Times one conversion in master clock cycles, h per half converter cycle; tot of zero skips the length and sample checks
  task automatic conv(int h, int tot, int smp);
    k = 0;
    s = 0;
    while (o_converting !== 1'b1) begin
      tick();
      k++;
      if (k > 600) hang("start");
    end
    k = 0;
    while (o_conversion_done_flag !== 1'b1) begin
      if (o_sample_hold === 1'b1) s = k;
      chk("busy start bit", 1, o_start_conversion_bit);
      tick();
      k++;
      if (k > 600) hang("done");
    end
    if (tot > 0) begin
      chk("length", tot * h, k);
      chk("sample to done", (tot - smp) * h, k - s);
    end
    chk("request", 1, o_complete_request);
    pulse(i_done_flag_clear);
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    i_mclk = 0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    {i_converter_enable, i_start_write, i_auto_trigger_enable, i_free_running} = '0;
    {i_trigger, i_select_write, i_sleep_halted, saturate} = '0;
    {i_result_low_read, i_result_high_read, i_done_flag_clear} = '0;
    i_clock_divide_select = 3'h0;
    i_channel_select_field = 5'h00;
    i_reference_select_field = 2'h0;
    i_nrst = 0;
    fail_count = 0;
    checked = 0;
    tick(3);
    chk("reset outputs", 0, {o_start_conversion_bit, o_conversion_done_flag,
      o_converting, o_sample_hold, o_complete_request, o_active_channel});
    chk("reset result", 10'h000, o_result);
    i_nrst = 1;
    tick(4);
    i_converter_enable = 1;
    sel(5'h03, 2'h1);
    tick(2);
    chk("follow channel", 5'h03, o_active_channel);
    pulse(i_start_write);
    chk("start bit", 1, o_start_conversion_bit);
    conv(1, 50, 29);
    chk("result", code(1, 3), o_result);
    chk("single start bit", 0, o_start_conversion_bit);
    $display("test first conversion done");
    i_clock_divide_select = 3'h2;
    pulse(i_start_write);
    conv(2, 26, 3);
    $display("test divided conversion done");
    pulse(i_result_low_read);
    saturate = 1;
    pulse(i_start_write);
    tick(8);
    sel(5'h09, 2'h2);
    tick(2);
    chk("locked channel", 5'h03, o_active_channel);
    conv(2, 0, 0);
    chk("blocked result", code(1, 3), o_result);
    chk("released channel", 5'h09, o_active_channel);
    chk("released reference", 2'h2, o_active_reference);
    pulse(i_result_high_read);
    pulse(i_start_write);
    conv(2, 0, 0);
    chk("full scale", 10'h3FF, o_result);
    saturate = 0;
    $display("test lock and read block done");
    i_clock_divide_select = 3'h0;
    i_auto_trigger_enable = 1;
    i_trigger = 1;
    tick(3);
    chk("trigger sync", 0, o_converting);
    tick();
    chk("trigger start", 1, o_converting);
    conv(1, 27, 4);
    i_trigger = 0;
    tick();
    i_trigger = 1;
    tick(6);
    i_trigger = 0;
    tick(2);
    i_trigger = 1;
    conv(1, 0, 0);
    tick(6);
    chk("ignored edge", 0, o_converting);
    i_trigger = 0;
    $display("test auto trigger done");
    sel(5'h04, 2'h1);
    i_free_running = 1;
    pulse(i_start_write);
    conv(1, 26, 3);
    chk("running start bit", 1, o_start_conversion_bit);
    sel(5'h06, 2'h1);
    conv(1, 0, 0);
    chk("old channel", code(1, 4), o_result);
    conv(1, 0, 0);
    chk("new channel", code(1, 6), o_result);
    {i_free_running, i_auto_trigger_enable} = '0;
    conv(1, 0, 0);
    $display("test free running done");
    i_sleep_halted = 1;
    tick();
    i_sleep_halted = 0;
    chk("sleep start bit", 1, o_start_conversion_bit);
    conv(1, 26, 3);
    $display("test sleep start done");
    i_converter_enable = 0;
    tick(3);
    i_converter_enable = 1;
    pulse(i_start_write);
    conv(1, 50, 29);
    $display("test re-enable done");
    end_of_test();
  end
endmodule
